// >>> core/fbh_pkg.sv
// Shared constants and types for the parallel flash bus host.
// Assumes a single 25 MHz clock; all pin timing is counted in its cycles.
package fbh_pkg;

  // Clock period of mclk in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;

  // Pin widths of the flash bus.
  localparam int LOC_W = 21;
  localparam int BYTE_W = 8;

  // Width of the shared delay counter.
  localparam int CNT_W = 8;

  // Stages of every pin synchroniser.
  localparam int SYNC_CYC = 2;

  // Pin-edge times in nanoseconds; plain defaults, tune to the part fitted.
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int READ_AFTER_RESET_DELAY_NS = 50;
  localparam int SELECT_ACCESS_TIME_NS = 70;
  localparam int WRITE_PULSE_NS = 50;

  // Least times round up to whole cycles, never below one.
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Derived cycle counts.
  localparam int RP_CYC = ceil_cyc(RESET_PULSE_MIN_NS);
  localparam int RH_CYC = ceil_cyc(READ_AFTER_RESET_DELAY_NS);
  localparam int RD_ACCESS_CYC = ceil_cyc(SELECT_ACCESS_TIME_NS) + SYNC_CYC;
  localparam int WE_PULSE_CYC = ceil_cyc(WRITE_PULSE_NS);

  // Bus sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_WAIT = 3'h1,
    ST_WR_SETUP = 3'h2,
    ST_WR_PULSE = 3'h3,
    ST_WR_HOLD = 3'h4,
    ST_RST_PULSE = 3'h5,
    ST_RST_RECOVER = 3'h6
  } fbh_state_t;

endpackage

// >>> core/fbh_delay.sv
// Down-counter that times one pin phase of the flash bus host.
// Assumes the loader only reloads it when the phase starts.
`timescale 1ns/100ps
module fbh_delay #(
  parameter int W = 8,
  parameter int RESET_VALUE = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  output logic expired
);

  // Refuse a reset count that the counter cannot hold.
  if (RESET_VALUE < 0 || RESET_VALUE >= (1 << W)) begin : g_bad_reset
    $error("fbh_delay reset value does not fit the counter");
  end

  // Remaining cycles of the running phase.
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Next count: load wins, otherwise count down and rest at zero.
  always_comb begin
    if (load) begin
      cnt_nxt = loadValue;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // The count restarts at the reset value so a phase begun by reset is timed.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_r <= W'(RESET_VALUE);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Expiry is seen in the cycle the count reaches zero.
  assign expired = (cnt_r == '0);

endmodule

// >>> core/fbh_host.sv
// Host-side sequencer that drives an asynchronous 8-bit parallel flash.
// Assumes the flash pins sit outside mclk; every pin input is synchronised.
`timescale 1ns/100ps
module fbh_host (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [fbh_pkg::LOC_W-1:0] reqAddr,
  input wire logic [fbh_pkg::BYTE_W-1:0] reqData,
  output logic reqReady,
  input wire logic hwResetReq,
  output logic rspValid,
  output logic [fbh_pkg::BYTE_W-1:0] rspData,
  output logic deviceBusy,
  output logic reissueNeeded,
  output logic flashSelectN,
  output logic outputGateN,
  output logic writeStrobeN,
  output logic hwResetN,
  output logic [fbh_pkg::LOC_W-1:0] locationLines,
  output logic [fbh_pkg::BYTE_W-1:0] byteLinesOut,
  output logic byteLinesDriveN,
  input wire logic [fbh_pkg::BYTE_W-1:0] byteLinesIn,
  input wire logic operationDoneN
);

  // Refuse a reset-pulse or read-access count that the shared counter cannot hold.
  if (fbh_pkg::RP_CYC >= (1 << fbh_pkg::CNT_W) ||
      fbh_pkg::RD_ACCESS_CYC >= (1 << fbh_pkg::CNT_W)) begin : g_bad_cnt
    $error("fbh_host timing count does not fit the counter");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stages feed only the second stages.
  logic [fbh_pkg::BYTE_W-1:0] byteMeta_r;
  logic [fbh_pkg::BYTE_W-1:0] byteSync_r;
  logic doneMeta_r;
  logic doneSync_r;

  // Two flops per pin; the done line idles high (ready) out of reset.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      byteMeta_r <= 8'h00;
      byteSync_r <= 8'h00;
      doneMeta_r <= 1'b1;
      doneSync_r <= 1'b1;
    end else begin
      byteMeta_r <= byteLinesIn;
      byteSync_r <= byteMeta_r;
      doneMeta_r <= operationDoneN;
      doneSync_r <= doneMeta_r;
    end
  end

  // Busy while the device reports an embedded operation in progress.
  assign deviceBusy = ~doneSync_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state and pin registers.
  fbh_pkg::fbh_state_t state_r;
  fbh_pkg::fbh_state_t state_nxt;
  logic ceN_r;
  logic ceN_nxt;
  logic oeN_r;
  logic oeN_nxt;
  logic weN_r;
  logic weN_nxt;
  logic rstN_r;
  logic rstN_nxt;
  logic [fbh_pkg::LOC_W-1:0] loc_r;
  logic [fbh_pkg::LOC_W-1:0] loc_nxt;
  logic [fbh_pkg::BYTE_W-1:0] dOut_r;
  logic [fbh_pkg::BYTE_W-1:0] dOut_nxt;
  logic dDriveN_r;
  logic dDriveN_nxt;
  logic [fbh_pkg::BYTE_W-1:0] rspData_r;
  logic [fbh_pkg::BYTE_W-1:0] rspData_nxt;
  logic rspValid_r;
  logic rspValid_nxt;
  logic reissue_r;
  logic reissue_nxt;
  // Phase timer control.
  logic tLoad;
  logic [fbh_pkg::CNT_W-1:0] tValue;
  logic tExpired;

  // One timer serves the read, write-pulse and reset phases; only one phase runs at a time.
  fbh_delay #(
    .W(fbh_pkg::CNT_W),
    .RESET_VALUE(fbh_pkg::RP_CYC)
  ) u_delay (
    .mclk(mclk),
    .resetn(resetn),
    .load(tLoad),
    .loadValue(tValue),
    .expired(tExpired)
  );

  // New requests are taken only from idle and never beside a reset request.
  assign reqReady = (state_r == fbh_pkg::ST_IDLE) && !hwResetReq;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic of the bus sequencer.
  always_comb begin
    state_nxt = state_r;
    ceN_nxt = ceN_r;
    oeN_nxt = oeN_r;
    weN_nxt = weN_r;
    rstN_nxt = rstN_r;
    loc_nxt = loc_r;
    dOut_nxt = dOut_r;
    dDriveN_nxt = dDriveN_r;
    rspData_nxt = rspData_r;
    rspValid_nxt = 1'b0;
    reissue_nxt = reissue_r;
    tLoad = 1'b0;
    tValue = '0;
    case (state_r)
      fbh_pkg::ST_IDLE: begin
        // Idle leaves select high so the device sits in standby.
        if (hwResetReq) begin
          // A reset that lands on a busy device aborts its work.
          if (deviceBusy) begin
            reissue_nxt = 1'b1;
          end
          rstN_nxt = 1'b0;
          tLoad = 1'b1;
          tValue = fbh_pkg::CNT_W'(fbh_pkg::RP_CYC);
          state_nxt = fbh_pkg::ST_RST_PULSE;
        end else if (reqValid) begin
          loc_nxt = reqAddr;
          ceN_nxt = 1'b0;
          if (reqWrite) begin
            // Strobe stays high one cycle so the address settles first.
            dOut_nxt = reqData;
            dDriveN_nxt = 1'b0;
            reissue_nxt = 1'b0;
            state_nxt = fbh_pkg::ST_WR_SETUP;
          end else begin
            oeN_nxt = 1'b0;
            tLoad = 1'b1;
            tValue = fbh_pkg::CNT_W'(fbh_pkg::RD_ACCESS_CYC);
            state_nxt = fbh_pkg::ST_RD_WAIT;
          end
        end
      end
      fbh_pkg::ST_RD_WAIT: begin
        // Array, identification or status byte: same read timing.
        if (tExpired) begin
          rspData_nxt = byteSync_r;
          rspValid_nxt = 1'b1;
          ceN_nxt = 1'b1;
          oeN_nxt = 1'b1;
          state_nxt = fbh_pkg::ST_IDLE;
        end
      end
      fbh_pkg::ST_WR_SETUP: begin
        weN_nxt = 1'b0;
        tLoad = 1'b1;
        tValue = fbh_pkg::CNT_W'(fbh_pkg::WE_PULSE_CYC);
        state_nxt = fbh_pkg::ST_WR_PULSE;
      end
      fbh_pkg::ST_WR_PULSE: begin
        // Strobe rises before select so the device latches on the strobe.
        if (tExpired) begin
          weN_nxt = 1'b1;
          state_nxt = fbh_pkg::ST_WR_HOLD;
        end
      end
      fbh_pkg::ST_WR_HOLD: begin
        // Data is held one cycle past the strobe edge, then released.
        ceN_nxt = 1'b1;
        dDriveN_nxt = 1'b1;
        rspValid_nxt = 1'b1;
        state_nxt = fbh_pkg::ST_IDLE;
      end
      fbh_pkg::ST_RST_PULSE: begin
        // Every strobe is parked high; the device ignores them anyway.
        ceN_nxt = 1'b1;
        oeN_nxt = 1'b1;
        weN_nxt = 1'b1;
        dDriveN_nxt = 1'b1;
        if (tExpired) begin
          rstN_nxt = 1'b1;
          tLoad = 1'b1;
          tValue = fbh_pkg::CNT_W'(fbh_pkg::RH_CYC);
          state_nxt = fbh_pkg::ST_RST_RECOVER;
        end
      end
      fbh_pkg::ST_RST_RECOVER: begin
        // Wait both the recovery delay and the device's ready indication.
        if (tExpired && doneSync_r) begin
          state_nxt = fbh_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = fbh_pkg::ST_IDLE;
      end
    endcase
  end

  // After our own reset the device is reset too, so it reads the array.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= fbh_pkg::ST_RST_PULSE;
      ceN_r <= 1'b1;
      oeN_r <= 1'b1;
      weN_r <= 1'b1;
      rstN_r <= 1'b0;
      loc_r <= 21'h000000;
      dOut_r <= 8'h00;
      dDriveN_r <= 1'b1;
      rspData_r <= 8'h00;
      rspValid_r <= 1'b0;
      reissue_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ceN_r <= ceN_nxt;
      oeN_r <= oeN_nxt;
      weN_r <= weN_nxt;
      rstN_r <= rstN_nxt;
      loc_r <= loc_nxt;
      dOut_r <= dOut_nxt;
      dDriveN_r <= dDriveN_nxt;
      rspData_r <= rspData_nxt;
      rspValid_r <= rspValid_nxt;
      reissue_r <= reissue_nxt;
    end
  end

  // Pins and the user outputs below come straight from flops; reqReady is decoded from state_r and hwResetReq.
  assign flashSelectN = ceN_r;
  assign outputGateN = oeN_r;
  assign writeStrobeN = weN_r;
  assign hwResetN = rstN_r;
  assign locationLines = loc_r;
  assign byteLinesOut = dOut_r;
  assign byteLinesDriveN = dDriveN_r;
  assign rspData = rspData_r;
  assign rspValid = rspValid_r;
  assign reissueNeeded = reissue_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks. Helper counters saturate so long idles do not wrap.
  logic [7:0] selLowCnt_r;
  logic [7:0] sinceRelCnt_r;
  logic [7:0] rstLowCnt_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      selLowCnt_r <= 8'h00;
      sinceRelCnt_r <= 8'h00;
      rstLowCnt_r <= 8'h00;
    end else begin
      selLowCnt_r <= ceN_r ? 8'h00 :
                     (selLowCnt_r == 8'hFF ? 8'hFF : selLowCnt_r + 8'h01);
      sinceRelCnt_r <= !rstN_r ? 8'h00 :
                     (sinceRelCnt_r == 8'hFF ? 8'hFF : sinceRelCnt_r + 8'h01);
      rstLowCnt_r <= rstN_r ? 8'h00 :
                     (rstLowCnt_r == 8'hFF ? 8'hFF : rstLowCnt_r + 8'h01);
    end
  end

  property p_read_levels;
    @(posedge mclk) disable iff (!resetn)
      !oeN_r |-> (!ceN_r && weN_r && rstN_r && dDriveN_r);
  endproperty
  a_read_levels: assert property (p_read_levels)
    else $error("read cycle pin levels wrong");

  property p_write_levels;
    @(posedge mclk) disable iff (!resetn)
      !weN_r |-> (!ceN_r && oeN_r && !dDriveN_r);
  endproperty
  a_write_levels: assert property (p_write_levels)
    else $error("write cycle pin levels wrong");

  property p_access_wait;
    @(posedge mclk) disable iff (!resetn)
      rspValid_r && weN_r && $past(state_r) == fbh_pkg::ST_RD_WAIT
      |-> $past(selLowCnt_r) >= 8'(fbh_pkg::RD_ACCESS_CYC);
  endproperty
  a_access_wait: assert property (p_access_wait)
    else $error("read data taken before select access time");

  property p_recovery;
    @(posedge mclk) disable iff (!resetn)
      $fell(oeN_r) |-> sinceRelCnt_r > 8'(fbh_pkg::RH_CYC);
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("read began inside reset recovery");

  property p_reset_width;
    @(posedge mclk) disable iff (!resetn)
      $rose(rstN_r) |-> $past(rstLowCnt_r) >= 8'(fbh_pkg::RP_CYC);
  endproperty
  a_reset_width: assert property (p_reset_width)
    else $error("reset pulse shorter than minimum");

  property p_reissue;
    @(posedge mclk) disable iff (!resetn)
      (state_r == fbh_pkg::ST_IDLE && hwResetReq && deviceBusy)
      |=> reissue_r ##1 !rstN_r;
  endproperty
  a_reissue: assert property (p_reissue)
    else $error("aborted operation not flagged for reissue");

  property p_reset_strobes;
    @(posedge mclk) disable iff (!resetn)
      !rstN_r |-> (ceN_r && oeN_r && weN_r && dDriveN_r)[*2];
  endproperty
  a_reset_strobes: assert property (p_reset_strobes)
    else $error("strobes active while device reset held");

endmodule

// >>> verification/fbh_flash_model.sv
// Behavioural model of the parallel flash seen from the bus host.
// Assumes the pins come from fbh_host; internal work ticks every 10 ns.
`timescale 1ns/100ps
module fbh_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5C, // Arbitrary identification value.
  parameter int PROG_STEPS = 150, // Program time in 10 ns steps.
  parameter int RDY_BUSY = 100, // Reset completion while busy.
  parameter int RDY_IDLE = 20 // Shorter reset completion while idle.
) (
  input wire logic flashSelectN,
  input wire logic outputGateN,
  input wire logic writeStrobeN,
  input wire logic hwResetN,
  input wire logic [fbh_pkg::LOC_W-1:0] locationLines,
  input wire logic [fbh_pkg::BYTE_W-1:0] byteLinesOut,
  input wire logic byteLinesDriveN,
  output logic [fbh_pkg::BYTE_W-1:0] byteLinesIn,
  output logic operationDoneN
);
  logic [7:0] mem [int]; // Programmed bytes; absent ones read erased.
  logic [7:0] lastVal = 8'h00; // Last byte seen on the data lines.
  logic [7:0] progData = 8'h00; // Byte being programmed.
  logic [7:0] rdVal; // Byte the device would drive now.
  logic [fbh_pkg::LOC_W-1:0] cmdAddr = '0; // Latched command address.
  logic idMode = 1'b0; // Identification codes replace array data.
  logic armProg = 1'b0; // Next write is a program byte.
  int progLeft = 0; // Steps left of the running program or erase.
  int rdyLeft = 0; // Steps left of the internal reset.
  logic [31:0] eraseMask = '0; // Sectors chosen for the next erase.
  logic armErase = 1'b0; // Erase set-up seen; sectors may be chosen.
  logic eraseRun = 1'b0; // The running embedded work is an erase.
  logic [7:0] keep [int]; // Scratch store while an erase rebuilds mem.
  logic wrActive;
  logic drvOn;

  ////////////////////////////////////////////////////////////////////////
  // Pin decode; reset low forces standby whatever the strobes say.
  assign wrActive = !flashSelectN && !writeStrobeN && outputGateN && hwResetN;
  assign drvOn = !flashSelectN && !outputGateN && writeStrobeN && hwResetN;

  // Status during program or erase, codes in id mode, array data otherwise.
  always @* begin
    if (progLeft != 0)
      rdVal = {~progData[7], 7'h00};
    else if (idMode)
      rdVal = ID_CODE;
    else
      rdVal = mem.exists(int'(locationLines)) ? mem[int'(locationLines)] : 8'hFF;
  end

  // Released lines show the inverse of the last byte, so stale data fails.
  always @* begin
    if (!byteLinesDriveN)
      lastVal = byteLinesOut;
    else if (drvOn)
      lastVal = rdVal;
  end
  assign byteLinesIn = (!byteLinesDriveN || drvOn) ? lastVal : ~lastVal;

  ////////////////////////////////////////////////////////////////////////
  // Address on the later fall, data on the earlier rise of the strobes.
  always @(posedge wrActive)
    cmdAddr = locationLines;
  always @(negedge wrActive) begin
    if (progLeft == 0 && rdyLeft == 0) begin
      if (armProg) begin
        progData = byteLinesIn;
        progLeft = PROG_STEPS;
        armProg = 1'b0;
      end else begin
        case (byteLinesIn)
          8'hF0: begin
            idMode = 1'b0;
            armProg = 1'b0;
            armErase = 1'b0;
          end
          8'h90: idMode = 1'b1;
          8'hA0: armProg = 1'b1;
          8'h80: begin
            armErase = 1'b1;
            eraseMask = '0;
          end
          // Each sector write adds the sector its top five bits name.
          8'h30: if (armErase) eraseMask[cmdAddr[20:16]] = 1'b1;
          8'h10: if (armErase) begin
            // No sector chosen means the whole chip.
            if (eraseMask == '0)
              eraseMask = '1;
            progData = 8'hFF;
            progLeft = PROG_STEPS;
            eraseRun = 1'b1;
            armErase = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // Embedded work runs on whether or not the device stays selected.
  always #10 begin
    if (progLeft == 1 && eraseRun) begin
      // Rebuild the store without the bytes of the chosen sectors.
      keep.delete();
      foreach (mem[k])
        if (!eraseMask[(k >> 16) & 31])
          keep[k] = mem[k];
      mem = keep;
      eraseRun = 1'b0;
    end else if (progLeft == 1)
      mem[int'(cmdAddr)] = progData;
    if (progLeft != 0)
      progLeft = progLeft - 1;
    if (rdyLeft != 0)
      rdyLeft = rdyLeft - 1;
  end

  // Reset aborts at once; busy holds until the internal reset ends.
  always @(negedge hwResetN) begin
    rdyLeft = (progLeft != 0) ? RDY_BUSY : RDY_IDLE;
    progLeft = 0;
    idMode = 1'b0;
    armProg = 1'b0;
    armErase = 1'b0;
    eraseRun = 1'b0;
  end
  assign operationDoneN = (progLeft == 0) && (rdyLeft == 0);
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the flash bus host against the flash model.
// Assumes fbh_pkg is compiled first; inputs change at falling edges.
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic wr;
    logic [20:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
    logic idle;
  } fbh_row_t;
  localparam logic [7:0] ID_CODE = 8'h5C; // Arbitrary identification value.
  logic mclk, resetn, reqValid, reqWrite, hwResetReq, reqReady, rspValid;
  logic deviceBusy, reissueNeeded, flashSelectN, outputGateN, writeStrobeN;
  logic hwResetN, byteLinesDriveN, operationDoneN;
  logic [fbh_pkg::LOC_W-1:0] reqAddr, locationLines;
  logic [fbh_pkg::BYTE_W-1:0] reqData, rspData, byteLinesOut, byteLinesIn;
  logic [7:0] got; // Byte returned by the last operation.
  int mismatches = 0;
  int checksDone = 0;
  int cycles = 0;
  // Read array, id mode, back to array, program, status, programmed byte.
  fbh_row_t rows [9] = '{
    '{1'b0, 21'h1F0000, 8'h00, 8'hFF, 1'b0},
    '{1'b1, 21'h000555, 8'h90, 8'h00, 1'b0},
    '{1'b0, 21'h000000, 8'h00, ID_CODE, 1'b0},
    '{1'b1, 21'h000555, 8'hF0, 8'h00, 1'b0},
    '{1'b0, 21'h000000, 8'h00, 8'hFF, 1'b0},
    '{1'b1, 21'h000555, 8'hA0, 8'h00, 1'b0},
    '{1'b1, 21'h012345, 8'h3C, 8'h00, 1'b0},
    '{1'b0, 21'h012345, 8'h00, 8'h80, 1'b0},
    '{1'b0, 21'h012345, 8'h00, 8'h3C, 1'b1}};

  fbh_host u_fbh_host (.mclk(mclk), .resetn(resetn), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .hwResetReq(hwResetReq), .rspValid(rspValid),
    .rspData(rspData), .deviceBusy(deviceBusy),
    .reissueNeeded(reissueNeeded), .flashSelectN(flashSelectN),
    .outputGateN(outputGateN), .writeStrobeN(writeStrobeN),
    .hwResetN(hwResetN), .locationLines(locationLines),
    .byteLinesOut(byteLinesOut), .byteLinesDriveN(byteLinesDriveN),
    .byteLinesIn(byteLinesIn), .operationDoneN(operationDoneN));

  fbh_flash_model #(.ID_CODE(ID_CODE)) u_fbh_flash_model (
    .flashSelectN(flashSelectN), .outputGateN(outputGateN),
    .writeStrobeN(writeStrobeN), .hwResetN(hwResetN),
    .locationLines(locationLines), .byteLinesOut(byteLinesOut),
    .byteLinesDriveN(byteLinesDriveN), .byteLinesIn(byteLinesIn),
    .operationDoneN(operationDoneN));

  ////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling well above the few hundred cycles needed.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      testDone();
    end
  end

  // Compare and count; four-state equality so unknowns never match.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic testDone();
    if (mismatches == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One request held until taken, then the answer pulse is awaited.
  task automatic doOp(input logic wr, input logic [20:0] addr,
      input logic [7:0] data, output logic [7:0] rd);
    int n;
    n = 0;
    reqWrite = wr;
    reqAddr = addr;
    reqData = data;
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check(8'(rspValid), 8'h01);
    rd = rspData;
  endtask

  // Bounded wait for the synchronised busy flag to reach a level.
  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    while (deviceBusy !== lvl && n < 200) begin
      @(negedge mclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqData = '0;
    hwResetReq = 1'b0;
    // Two rising edges under reset, then look half a cycle later.
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(8'({hwResetN, flashSelectN}), 8'h01);
    resetn = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].idle)
        waitBusy(1'b0);
      doOp(rows[i].wr, rows[i].addr, rows[i].data, got);
      if (!rows[i].wr)
        check(got, rows[i].exp);
      check(8'(flashSelectN), 8'h01);
    end
    // Reset in mid-program: the read is held off, then sees erased data.
    doOp(1'b1, 21'h000555, 8'hA0, got);
    doOp(1'b1, 21'h020000, 8'h55, got);
    waitBusy(1'b1);
    hwResetReq = 1'b1;
    @(negedge mclk);
    hwResetReq = 1'b0;
    doOp(1'b0, 21'h020000, 8'h00, got);
    check(got, 8'hFF);
    check(8'(reissueNeeded), 8'h01);
    check(8'(deviceBusy), 8'h00);
    doOp(1'b1, 21'h000555, 8'hF0, got);
    check(8'(reissueNeeded), 8'h00);
    // Idle reset: nothing to reissue and array reads resume.
    hwResetReq = 1'b1;
    @(negedge mclk);
    hwResetReq = 1'b0;
    doOp(1'b0, 21'h012345, 8'h00, got);
    check(got, 8'h3C);
    check(8'(reissueNeeded), 8'h00);
    // Erase two sectors, a third keeps its byte; then the whole chip.
    doOp(1'b1, 21'h000555, 8'hA0, got);
    doOp(1'b1, 21'h1F0000, 8'h5A, got);
    waitBusy(1'b1);
    waitBusy(1'b0);
    doOp(1'b1, 21'h000555, 8'h80, got);
    doOp(1'b1, 21'h000000, 8'h30, got);
    doOp(1'b1, 21'h010000, 8'h30, got);
    doOp(1'b1, 21'h000555, 8'h10, got);
    waitBusy(1'b1);
    waitBusy(1'b0);
    doOp(1'b0, 21'h012345, 8'h00, got);
    check(got, 8'hFF);
    doOp(1'b0, 21'h1F0000, 8'h00, got);
    check(got, 8'h5A);
    doOp(1'b1, 21'h000555, 8'h80, got);
    doOp(1'b1, 21'h000555, 8'h10, got);
    doOp(1'b0, 21'h1F0000, 8'h00, got);
    check(got, 8'h00);
    waitBusy(1'b0);
    doOp(1'b0, 21'h1F0000, 8'h00, got);
    check(got, 8'hFF);
    testDone();
  end
endmodule
